// ===== core/dual_temp_conversion_readout.v
// conversion sequencer, result registers and byte-wide serial slave
`timescale 1ns/1ps
`include "temp_readout_defines.vh"
`default_nettype none

module dual_temp_conversion_readout #(
    parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR,
    parameter [31:0] CONV_CYCLES = `CONV_TIME_MS * 1000 * `CLK_MHZ,
    parameter [31:0] TIMEOUT_CYCLES = `BUS_TIMEOUT_MS * 1000 * `CLK_MHZ
) (
    input wire mclk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire [11:0] local_raw_i,
    input wire [11:0] remote_raw_i,
    input wire remote_fault_i,
    output wire busy_o,
    output wire remote_phase_o
);

localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_ADDR = 3'd1;
localparam [2:0] ST_AACK = 3'd2;
localparam [2:0] ST_RX = 3'd3;
localparam [2:0] ST_RACK = 3'd4;
localparam [2:0] ST_TX = 3'd5;
localparam [2:0] ST_TACK = 3'd6;

////////////////////////////////////////////////////////////////////////////
// result formatting: {integer, fraction}
function [10:0] fmt;
    input [11:0] t;
    begin
        if (t[11])
            fmt = {`TEMP_MIN_CODE, `FRAC_ZERO};
        else if (t >= `TEMP_CLAMP_RAW)
            fmt = {`TEMP_MAX_CODE, `FRAC_MAX};
        else
            // 8 lsb per degree, fault bit clear
            fmt = {1'b0, t[9:3], t[2:0]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
reg sda_s1_ff, sda_s2_ff, sda_s3_ff;

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        scl_s1_ff <= 1'b1;
        scl_s2_ff <= 1'b1;
        scl_s3_ff <= 1'b1;
        sda_s1_ff <= 1'b1;
        sda_s2_ff <= 1'b1;
        sda_s3_ff <= 1'b1;
    end else begin
        scl_s1_ff <= scl_i;
        scl_s2_ff <= scl_s1_ff;
        scl_s3_ff <= scl_s2_ff;
        sda_s1_ff <= sda_i;
        sda_s2_ff <= sda_s1_ff;
        sda_s3_ff <= sda_s2_ff;
    end
end

wire scl_rise = scl_s2_ff & ~scl_s3_ff;
wire scl_fall = ~scl_s2_ff & scl_s3_ff;
wire start_cond = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
wire stop_cond = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;

////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] ptr_ff;
reg standby_ff;
reg busy_ff;
reg single_ff;
reg [31:0] conv_cnt_ff;
reg [7:0] local_int_ff, remote_int_ff;
reg [2:0] local_frac_ff, remote_frac_ff;
reg one_shot_req_ff;
reg cfg_wr_ff;
reg [7:0] cfg_data_ff;
reg remote_phase_ff;

reg [7:0] rd_data;
always @* begin
    case (ptr_ff)
        `REG_LOCAL_INT: rd_data = local_int_ff;
        `REG_REMOTE_INT: rd_data = remote_int_ff;
        `REG_REMOTE_FRAC: rd_data = {remote_frac_ff, 5'h00};
        `REG_LOCAL_FRAC: rd_data = {local_frac_ff, 5'h00};
        `REG_STATUS: rd_data = {busy_ff, 7'h00};
        `REG_CFG_RD: rd_data = {1'b0, standby_ff, 6'h00};
        default: rd_data = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// conversion sequencer
wire [10:0] local_fmt = fmt(local_raw_i);
wire [10:0] remote_fmt = fmt(remote_raw_i);
wire nxt_standby = cfg_wr_ff ? cfg_data_ff[`CFG_STANDBY_BIT] : standby_ff;
wire conv_done = busy_ff && (conv_cnt_ff == CONV_CYCLES - 32'd1);

always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        standby_ff <= 1'b0;
        busy_ff <= 1'b0;
        single_ff <= 1'b0;
        conv_cnt_ff <= 32'd0;
        remote_phase_ff <= 1'b0;
        local_int_ff <= `TEMP_MIN_CODE;
        remote_int_ff <= `TEMP_MIN_CODE;
        local_frac_ff <= `FRAC_ZERO;
        remote_frac_ff <= `FRAC_ZERO;
    end else begin
        standby_ff <= nxt_standby;
        if (busy_ff) begin
            if (nxt_standby && !single_ff && cfg_wr_ff) begin
                busy_ff <= 1'b0;
                remote_phase_ff <= 1'b0;
            end else if (conv_done) begin
                busy_ff <= 1'b0;
                single_ff <= 1'b0;
                remote_phase_ff <= 1'b0;
                local_int_ff <= local_fmt[10:3];
                local_frac_ff <= local_fmt[2:0];
                if (remote_fault_i) begin
                    remote_int_ff <= `TEMP_FAULT_CODE;
                    remote_frac_ff <= `FRAC_ZERO;
                end else begin
                    remote_int_ff <= remote_fmt[10:3];
                    remote_frac_ff <= remote_fmt[2:0];
                end
            end else begin
                conv_cnt_ff <= conv_cnt_ff + 32'd1;
                // second half measures the remote junction
                if (conv_cnt_ff == (CONV_CYCLES >> 1))
                    remote_phase_ff <= 1'b1;
            end
        end else if (one_shot_req_ff) begin
            // one-shot runs whatever the standby bit
            busy_ff <= 1'b1;
            single_ff <= 1'b1;
            conv_cnt_ff <= 32'd0;
        end else if (!nxt_standby) begin
            busy_ff <= 1'b1;
            single_ff <= 1'b0;
            conv_cnt_ff <= 32'd0;
        end
        // one-shot while busy falls through unused
        // result registers only change at completion
    end
end

////////////////////////////////////////////////////////////////////////////
// serial slave
reg [2:0] state_ff;
reg [3:0] bit_cnt_ff;
reg [7:0] shift_ff;
reg first_byte_ff;
reg rd_dir_ff;
reg sda_oe_ff;
reg sda_o_ff;
reg [31:0] low_cnt_ff;

// slave is never gated by standby
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'd0;
        shift_ff <= 8'h00;
        first_byte_ff <= 1'b0;
        rd_dir_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
        sda_o_ff <= 1'b0;
        low_cnt_ff <= 32'd0;
        ptr_ff <= `PTR_RESET;
        one_shot_req_ff <= 1'b0;
        cfg_wr_ff <= 1'b0;
        cfg_data_ff <= 8'h00;
    end else begin
        one_shot_req_ff <= 1'b0;
        cfg_wr_ff <= 1'b0;
        sda_o_ff <= 1'b0;
        if (scl_s2_ff)
            low_cnt_ff <= 32'd0;
        else if (low_cnt_ff != TIMEOUT_CYCLES)
            low_cnt_ff <= low_cnt_ff + 32'd1;
        if (!scl_s2_ff && low_cnt_ff == TIMEOUT_CYCLES) begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (start_cond) begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'd0;
            sda_oe_ff <= 1'b0;
        end else if (stop_cond) begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_s2_ff};
                        bit_cnt_ff <= bit_cnt_ff + 4'd1;
                    end else if (scl_fall && bit_cnt_ff == 4'd8) begin
                        if (shift_ff[7:1] == SLAVE_ADDR) begin
                            state_ff <= ST_AACK;
                            sda_oe_ff <= 1'b1;
                            rd_dir_ff <= shift_ff[0];
                            first_byte_ff <= 1'b1;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (rd_dir_ff) begin
                            state_ff <= ST_TX;
                            shift_ff <= rd_data;
                            sda_oe_ff <= ~rd_data[7];
                            bit_cnt_ff <= 4'd1;
                        end else begin
                            state_ff <= ST_RX;
                            sda_oe_ff <= 1'b0;
                            bit_cnt_ff <= 4'd0;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_s2_ff};
                        bit_cnt_ff <= bit_cnt_ff + 4'd1;
                    end else if (scl_fall && bit_cnt_ff == 4'd8) begin
                        state_ff <= ST_RACK;
                        sda_oe_ff <= 1'b1;
                        first_byte_ff <= 1'b0;
                        // command byte then optional data byte
                        if (first_byte_ff) begin
                            // command byte moves the pointer and requests a one-shot for REG_ONE_SHOT
                            ptr_ff <= shift_ff;
                            if (shift_ff == `REG_ONE_SHOT)
                                one_shot_req_ff <= 1'b1;
                        end else if (ptr_ff == `REG_CFG_WR) begin
                            cfg_wr_ff <= 1'b1;
                            cfg_data_ff <= shift_ff;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        state_ff <= ST_RX;
                        sda_oe_ff <= 1'b0;
                        bit_cnt_ff <= 4'd0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == 4'd8) begin
                            state_ff <= ST_TACK;
                            sda_oe_ff <= 1'b0;
                        end else begin
                            sda_oe_ff <= ~shift_ff[6];
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'd1;
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        shift_ff[0] <= sda_s2_ff;
                    end else if (scl_fall) begin
                        if (shift_ff[0]) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            state_ff <= ST_TX;
                            shift_ff <= rd_data;
                            sda_oe_ff <= ~rd_data[7];
                            bit_cnt_ff <= 4'd1;
                        end
                    end
                end
                default: begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end
end

assign sda_o = sda_o_ff;
assign sda_oe_o = sda_oe_ff;
assign busy_o = busy_ff;
assign remote_phase_o = remote_phase_ff;

endmodule
`default_nettype wire

// ===== core/temp_readout_defines.vh
// constants for the dual temperature readout block
`ifndef TEMP_READOUT_DEFINES_VH
`define TEMP_READOUT_DEFINES_VH

// clock and timing
`define CLK_MHZ 125
`define CONV_TIME_MS 125
`define BUS_TIMEOUT_MS 35

// register pointer values
`define REG_LOCAL_INT 8'h00
`define REG_REMOTE_INT 8'h01
`define REG_STATUS 8'h02
`define REG_CFG_RD 8'h03
`define REG_CFG_WR 8'h09
`define REG_ONE_SHOT 8'h0f
`define REG_REMOTE_FRAC 8'h10
`define REG_LOCAL_FRAC 8'h11
`define PTR_RESET 8'h00

// field positions
`define CFG_STANDBY_BIT 6
`define STATUS_BUSY_BIT 7

// result encodings
`define TEMP_FAULT_CODE 8'h80
`define TEMP_MAX_CODE 8'h7f
`define TEMP_MIN_CODE 8'h00
`define TEMP_CLAMP_RAW 12'h400
`define FRAC_MAX 3'h7
`define FRAC_ZERO 3'h0

// slave address, arbitrary default
`define SLAVE_ADDR 7'h4c

`endif

// ===== testbench/temp_readout_chk.sv
// port-level assertions for the dual temperature readout block
`timescale 1ns/1ps
`default_nettype none
module temp_readout_chk #(
    parameter [31:0] CONV_CYCLES = 64,
    parameter [31:0] TIMEOUT_CYCLES = 200
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic busy_o,
    input wire logic remote_phase_o
);
    logic [31:0] busy_cnt_ff;
    logic [31:0] low_cnt_ff;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt_ff <= '0;
            low_cnt_ff <= '0;
        end else begin
            busy_cnt_ff <= busy_o ? busy_cnt_ff + 1 : '0;
            low_cnt_ff <= scl_i ? '0 : low_cnt_ff + 1;
        end
    end
    ////////////////////////////////////////////////////////////
    busy_max_a: assert property (busy_cnt_ff <= CONV_CYCLES + 1)
        else $error("conversion ran too long");
    phase_in_a: assert property (remote_phase_o |-> busy_o)
        else $error("remote phase outside conversion");
    // slack for the offset between sequencer count and this count
    phase_mid_a: assert property ($rose(remote_phase_o) |->
        busy_cnt_ff + 3 >= CONV_CYCLES / 2 &&
        busy_cnt_ff <= CONV_CYCLES / 2 + 3)
        else $error("remote phase not at half time");
    phase_end_a: assert property ($fell(busy_o) &&
        busy_cnt_ff >= CONV_CYCLES - 1 |-> $fell(remote_phase_o))
        else $error("remote phase missing at completion");
    sda_low_a: assert property (sda_o == 1'b0)
        else $error("data pin drives high");
    oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data changed while clock high");
    oe_late_a: assert property ($rose(sda_oe_o) |->
        $past(scl_i, 2) == 1'b0)
        else $error("data driven too soon after clock fall");
    bus_timeout_a: assert property (
        low_cnt_ff > TIMEOUT_CYCLES + 4 |-> !sda_oe_o)
        else $error("data held past clock low timeout");
    cover property ($fell(busy_o));
    cover property ($rose(remote_phase_o));
    cover property (low_cnt_ff > TIMEOUT_CYCLES + 4);
endmodule
bind dual_temp_conversion_readout temp_readout_chk #(
    .CONV_CYCLES(CONV_CYCLES),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_chk (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .busy_o(busy_o),
    .remote_phase_o(remote_phase_o)
);
`default_nettype wire

// ===== testbench/smbus_host_model.sv
// behavioural two-wire host that drives the block's serial slave
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model #(
    parameter int Q = 8
) (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // data only moves while clock is low
    task automatic clk_bit(input logic b, output logic r);
        sda_low_o <= ~b;
        tick(Q);
        scl_o <= 1'b1;
        tick(2 * Q);
        r = sda_i;
        scl_o <= 1'b0;
        tick(Q);
    endtask
    task automatic start();
        sda_low_o <= 1'b0;
        tick(Q);
        scl_o <= 1'b1;
        tick(Q);
        sda_low_o <= 1'b1;
        tick(Q);
        scl_o <= 1'b0;
        tick(Q);
    endtask
    task automatic stop();
        sda_low_o <= 1'b1;
        tick(Q);
        scl_o <= 1'b1;
        tick(Q);
        sda_low_o <= 1'b0;
        tick(2 * Q);
    endtask
    task automatic io(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--)
            clk_bit(tx[i], rx[i]);
        clk_bit(ack_tx, nak);
    endtask
    ////////////////////////////////////////////////////////////
    // kinds: 0 send, 1 write, 2 read, 3 receive
    task automatic xfer(input logic [6:0] a, input logic [1:0] k,
                        input logic [7:0] c, input logic [7:0] w,
                        output logic [7:0] r, output logic nak);
        logic [7:0] d;
        logic x;
        r = 8'h00;
        start();
        io({a, k == 2'd3}, 1'b1, d, nak);
        if (k != 2'd3) begin
            io(c, 1'b1, d, x);
            nak = nak | x;
            if (k == 2'd1) io(w, 1'b1, d, x);
            nak = nak | x;
            if (k == 2'd2) start();
            if (k == 2'd2) io({a, 1'b1}, 1'b1, d, x);
            nak = nak | x;
        end
        if (k[1]) io(8'hff, 1'b1, r, x);
        stop();
    endtask
endmodule
`default_nettype wire

// ===== testbench/test_dual_temp_conversion_readout.sv
// self-checking bench for the dual temperature readout block
`timescale 1ns/1ps
`default_nettype none
module test_dual_temp_conversion_readout;
    // long enough that four reads fit between two completions
    localparam logic [31:0] CONV = 32'd8000;
    localparam logic [31:0] TMO = 32'd200;
    // slave address value is arbitrary
    localparam logic [6:0] ADDR = 7'h21;
    localparam logic [31:0] PTRS = 32'h11100100;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] loc_raw = 12'h000;
    logic [11:0] rem_raw = 12'h000;
    logic fault = 1'b0;
    logic [11:0] lraw [2] = '{12'h0cb, 12'hf38};
    logic [11:0] rraw [2] = '{12'h410, 12'h000};
    logic [31:0] expv [2] = '{32'h60e07f19, 32'h00008000};
    logic [7:0] r;
    logic nak;
    logic b;
    int n_errors = 0;
    int n_checks = 0;
    int blen = 0;
    int blen0 = 0;
    wire scl;
    wire host_low;
    wire sda_o;
    wire sda_oe;
    wire busy;
    // open drain with pull-up: low if either side pulls
    wire sda = ~(host_low | sda_oe);
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk)
        if (busy === 1'b1) blen <= blen + 1;
    dual_temp_conversion_readout #(.SLAVE_ADDR(ADDR), .CONV_CYCLES(CONV),
        .TIMEOUT_CYCLES(TMO)) i_dut (.mclk_i(mclk), .rst_i(rst),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .local_raw_i(loc_raw), .remote_raw_i(rem_raw),
        .remote_fault_i(fault), .busy_o(busy), .remote_phase_o());
    smbus_host_model #(.Q(8)) i_host (.mclk_i(mclk), .sda_i(sda),
        .scl_o(scl), .sda_low_o(host_low));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [1:0] k, input logic [7:0] p,
                      input logic [7:0] exp);
        // exp doubles as the data byte of a write byte
        i_host.xfer(ADDR, k, p, exp, r, nak);
        chk({7'h00, nak}, 8'h00);
        if (k[1]) chk(r, exp);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_busy(input logic v);
        int t;
        t = 0;
        while (busy !== v && t < 3 * CONV) begin
            @(posedge mclk);
            t++;
        end
        if (busy !== v) begin
            n_errors++;
            $display("[FAIL] %0t busy wait ran out", $time);
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({7'h00, busy}, 8'h01);
        rd(2'd3, 8'h00, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            loc_raw <= lraw[i];
            rem_raw <= rraw[i];
            fault <= i[0];
            wait_busy(1'b1);
            wait_busy(1'b0);
            for (int j = 0; j < 4; j++)
                rd(2'd2, PTRS[8*j+:8],
                   expv[i][8*j+:8]);
        end
        $display("test formats done");
        wait_busy(1'b0);
        wait_busy(1'b1);
        loc_raw <= 12'h0cd;
        rem_raw <= 12'h1f8;
        fault <= 1'b0;
        rd(2'd1, 8'h09, 8'h40);
        chk({7'h00, busy}, 8'h00);
        rd(2'd2, 8'h00, 8'h00);
        rd(2'd2, 8'h01, 8'h80);
        repeat (CONV + 50) @(posedge mclk);
        chk({7'h00, busy}, 8'h00);
        $display("test standby done");
        blen0 = blen;
        rd(2'd0, 8'h0f, 8'h00);
        chk({7'h00, busy}, 8'h01);
        rd(2'd0, 8'h0f, 8'h00);
        rd(2'd2, 8'h02, 8'h80);
        wait_busy(1'b0);
        chk({7'h00, blen - blen0 >= CONV - 1 && blen - blen0 <= CONV + 1},
            8'h01);
        rd(2'd2, 8'h00, 8'h19);
        rd(2'd2, 8'h01, 8'h3f);
        rd(2'd3, 8'h00, 8'h3f);
        rd(2'd1, 8'h00, 8'hff);
        rd(2'd3, 8'h00, 8'h19);
        rd(2'd0, 8'h11, 8'h00);
        rd(2'd3, 8'h00, 8'ha0);
        chk({7'h00, busy}, 8'h00);
        $display("test one-shot done");
        i_host.xfer(ADDR ^ 7'h01, 2'd3, 8'h00, 8'h00, r, nak);
        chk({7'h00, nak}, 8'h01);
        i_host.start();
        for (int i = 6; i >= 0; i--)
            i_host.clk_bit(ADDR[i], b);
        i_host.clk_bit(1'b0, b);
        repeat (TMO + 20) @(posedge mclk);
        chk({7'h00, sda_oe}, 8'h00);
        i_host.stop();
        rd(2'd0, 8'h00, 8'h00);
        $display("test bus done");
        give_verdict();
    end
endmodule
`default_nettype wire
